// [rtl/synth2_control_regs.sv]
// control registers, sync gating and calibration sequencer of the second synthesizer
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
module synth2_control_regs #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              arst_n,
    // axi4-lite write address and data
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // analogue synthesizer side
    input  wire logic              cal_complete,
    output logic                   synth_enable,
    output logic                   cal_restart,
    output logic [3:0]             post_divide_ratio,
    output logic                   doubler_enable,
    output logic [3:0]             charge_pump_gain,
    output logic [4:0]             pump_current_steps,
    // channel resynchronisation
    input  wire logic              sync_event,
    output logic                   chan_resync
);

    // ****************************************
    // state
    // ****************************************
    logic [7:0]                    ctrl0_r, ctrl0_nxt;
    logic [7:0]                    ctrl1_r, ctrl1_nxt;
    logic                          aw_hold_r, aw_hold_nxt;
    logic                          w_hold_r, w_hold_nxt;
    logic [ADDR_W-1:0]             awaddr_r, awaddr_nxt;
    logic [7:0]                    wbyte_r, wbyte_nxt;
    logic                          wlane_r, wlane_nxt;
    logic                          bvalid_r, bvalid_nxt;
    logic [1:0]                    bresp_r, bresp_nxt;
    logic                          rvalid_r, rvalid_nxt;
    logic [31:0]                   rdata_r, rdata_nxt;
    logic [1:0]                    rresp_r, rresp_nxt;
    synth2_regs_pkg::cal_state_t   cal_r, cal_nxt;
    logic                          restart_r, restart_nxt;
    logic                          resync_r, resync_nxt;
    logic [3:0]                    div_r, div_nxt;
    logic [4:0]                    steps_r, steps_nxt;

    logic [2:0]                    div_code;
    logic [3:0]                    pump_code;
    logic                          do_write;

    assign div_code  = ctrl0_r[synth2_regs_pkg::POST_DIV_MSB:synth2_regs_pkg::POST_DIV_LSB];
    assign pump_code = ctrl1_r[synth2_regs_pkg::PUMP_MSB:synth2_regs_pkg::PUMP_LSB];
    assign do_write  = aw_hold_r && w_hold_r && !bvalid_r;

    // ****************************************
    // bus handshakes
    // ****************************************
    // address and data are taken independently, one write at a time
    assign s_axi_awready = !aw_hold_r && !bvalid_r;
    assign s_axi_wready  = !w_hold_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    // write channel and register update
    always_comb begin
        aw_hold_nxt = aw_hold_r;
        w_hold_nxt  = w_hold_r;
        awaddr_nxt  = awaddr_r;
        wbyte_nxt   = wbyte_r;
        wlane_nxt   = wlane_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        ctrl0_nxt   = ctrl0_r;
        ctrl1_nxt   = ctrl1_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_nxt = 1'b1;
            awaddr_nxt  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_nxt = 1'b1;
            wbyte_nxt  = s_axi_wdata[7:0];
            wlane_nxt  = s_axi_wstrb[0];
        end
        if (do_write) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = synth2_regs_pkg::RESP_OKAY;
            case (awaddr_r[7:0])
                synth2_regs_pkg::DIV_SYNC_PWR_ADDR: begin
                    if (wlane_r) begin
                        ctrl0_nxt = wbyte_r & synth2_regs_pkg::CTRL0_WR_MASK;
                    end
                end
                synth2_regs_pkg::PUMP_DBL_ADDR: begin
                    if (wlane_r) begin
                        ctrl1_nxt = wbyte_r & synth2_regs_pkg::CTRL1_WR_MASK;
                    end
                end
                synth2_regs_pkg::STATUS_ADDR: begin
                    bresp_nxt = synth2_regs_pkg::RESP_OKAY; // read-only, write ignored
                end
                default: begin
                    bresp_nxt = synth2_regs_pkg::RESP_SLVERR;
                end
            endcase
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
    end

    // read channel, one cycle after the address is taken
    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = synth2_regs_pkg::RESP_OKAY;
            rdata_nxt  = 32'h0000_0000;
            case (s_axi_araddr[7:0])
                synth2_regs_pkg::DIV_SYNC_PWR_ADDR: rdata_nxt[7:0] = ctrl0_r;
                synth2_regs_pkg::PUMP_DBL_ADDR:     rdata_nxt[7:0] = ctrl1_r;
                synth2_regs_pkg::STATUS_ADDR: begin
                    rdata_nxt[synth2_regs_pkg::STAT_CAL_LSB +: 3]  = cal_r;
                    rdata_nxt[synth2_regs_pkg::STAT_DIV_LSB +: 4]  = div_r;
                    rdata_nxt[synth2_regs_pkg::STAT_PUMP_LSB +: 5] = steps_r;
                end
                default: rresp_nxt = synth2_regs_pkg::RESP_SLVERR;
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    // ****************************************
    // synthesizer control
    // ****************************************
    // calibration sequencer and decodes
    always_comb begin
        cal_nxt     = cal_r;
        restart_nxt = 1'b0;
        case (cal_r)
            synth2_regs_pkg::CAL_OFF: begin
                if (!ctrl0_r[synth2_regs_pkg::PDN_BIT]) begin
                    cal_nxt     = synth2_regs_pkg::CAL_BUSY;
                    restart_nxt = 1'b1;
                end
            end
            synth2_regs_pkg::CAL_BUSY: begin
                if (cal_complete) begin
                    cal_nxt = synth2_regs_pkg::CAL_DONE;
                end
            end
            synth2_regs_pkg::CAL_DONE: cal_nxt = synth2_regs_pkg::CAL_DONE;
            default:                   cal_nxt = synth2_regs_pkg::CAL_OFF;
        endcase
        if (ctrl0_r[synth2_regs_pkg::PDN_BIT]) begin
            cal_nxt     = synth2_regs_pkg::CAL_OFF;
            restart_nxt = 1'b0;
        end
        resync_nxt = sync_event && ctrl0_r[synth2_regs_pkg::SYNC_EN_BIT];
        if (div_code <= synth2_regs_pkg::POST_DIV_MIN_CODE) begin
            div_nxt = synth2_regs_pkg::POST_DIV_MIN;
        end else begin
            div_nxt = {1'b0, div_code} + 4'h1;
        end
        if (pump_code == synth2_regs_pkg::PUMP_HIGH_CODE) begin
            steps_nxt = synth2_regs_pkg::PUMP_HIGH_STEPS;
        end else if (pump_code <= synth2_regs_pkg::PUMP_MAX_LIN) begin
            steps_nxt = {1'b0, pump_code};
        end else begin
            steps_nxt = 5'h00; // unsupported code, pump off
        end
    end

    // registers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl0_r   <= synth2_regs_pkg::DIV_SYNC_PWR_RST;
            ctrl1_r   <= synth2_regs_pkg::PUMP_DBL_RST;
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            awaddr_r  <= '0;
            wbyte_r   <= 8'h00;
            wlane_r   <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= synth2_regs_pkg::RESP_OKAY;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= synth2_regs_pkg::RESP_OKAY;
            cal_r     <= synth2_regs_pkg::CAL_OFF;
            restart_r <= 1'b0;
            resync_r  <= 1'b0;
            div_r     <= synth2_regs_pkg::POST_DIV_RST;
            steps_r   <= synth2_regs_pkg::PUMP_HIGH_STEPS;
        end else begin
            ctrl0_r   <= ctrl0_nxt;
            ctrl1_r   <= ctrl1_nxt;
            aw_hold_r <= aw_hold_nxt;
            w_hold_r  <= w_hold_nxt;
            awaddr_r  <= awaddr_nxt;
            wbyte_r   <= wbyte_nxt;
            wlane_r   <= wlane_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
            cal_r     <= cal_nxt;
            restart_r <= restart_nxt;
            resync_r  <= resync_nxt;
            div_r     <= div_nxt;
            steps_r   <= steps_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign synth_enable       = (cal_r != synth2_regs_pkg::CAL_OFF);
    assign cal_restart        = restart_r;
    assign chan_resync        = resync_r;
    assign post_divide_ratio  = div_r;
    assign doubler_enable     = ctrl1_r[synth2_regs_pkg::DOUBLER_BIT];
    assign charge_pump_gain   = pump_code;
    assign pump_current_steps = steps_r;

endmodule

// [rtl/synth2_regs_pkg.sv]
// constants, register map and state codes for the synthesizer control registers
package synth2_regs_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] DIV_SYNC_PWR_ADDR = 8'h44; // synth2_divider_sync_power_control
    localparam logic [7:0] PUMP_DBL_ADDR     = 8'h48; // synth2_pump_and_doubler_control
    localparam logic [7:0] STATUS_ADDR       = 8'h4C; // read-only state view

    // ****************************************
    // field positions
    // ****************************************
    localparam int POST_DIV_LSB  = 2;
    localparam int POST_DIV_MSB  = 4;
    localparam int SYNC_EN_BIT   = 1;
    localparam int PDN_BIT       = 0;
    localparam int RSVD_RW_BIT   = 5;
    localparam int DOUBLER_BIT   = 4;
    localparam int PUMP_LSB      = 0;
    localparam int PUMP_MSB      = 3;
    localparam int STAT_CAL_LSB  = 0;  // calibration state, one-hot, 3 bits
    localparam int STAT_DIV_LSB  = 4;  // decoded post divide ratio, 4 bits
    localparam int STAT_PUMP_LSB = 8;  // pump current in 0.4 mA steps, 5 bits

    // ****************************************
    // reset values and decode constants
    // ****************************************
    localparam logic [7:0] DIV_SYNC_PWR_RST = 8'h1E; // divider code 7, sync on, powered
    localparam logic [3:0] POST_DIV_RST     = 4'h8;  // ratio decoded from reset code 7
    localparam logic [7:0] PUMP_DBL_RST     = 8'h18; // doubler on, pump code 8
    localparam logic [7:0] CTRL0_WR_MASK    = 8'h1F;
    localparam logic [7:0] CTRL1_WR_MASK    = 8'h3F;
    localparam logic [2:0] POST_DIV_MIN_CODE = 3'h1;
    localparam logic [3:0] POST_DIV_MIN     = 4'h2;
    localparam logic [3:0] PUMP_MAX_LIN     = 4'h7;
    localparam logic [3:0] PUMP_HIGH_CODE   = 4'h8;
    localparam logic [4:0] PUMP_HIGH_STEPS  = 5'h10; // 6.4 mA in 0.4 mA steps
    localparam logic [1:0] RESP_OKAY        = 2'h0;
    localparam logic [1:0] RESP_SLVERR      = 2'h2;

    // ****************************************
    // calibration sequencer states
    // ****************************************
    typedef enum logic [2:0] {
        CAL_OFF  = 3'b001,
        CAL_BUSY = 3'b010,
        CAL_DONE = 3'b100
    } cal_state_t;

endpackage

// [sim/synth2_regs_properties.sv]
// port assertions for the synthesizer control registers
`timescale 1ns/1ps
module synth2_regs_checker (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       arst_n,
    // bus handshakes
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    // synthesizer side
    input wire logic       synth_enable,
    input wire logic       cal_restart,
    input wire logic [3:0] post_divide_ratio,
    input wire logic [3:0] charge_pump_gain,
    input wire logic [4:0] pump_current_steps,
    input wire logic       sync_event,
    input wire logic       chan_resync
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // ****************************************
    // assertions
    // ****************************************
    AST_B_LATENCY: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write answer dropped");
    AST_R_LATENCY: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read answer dropped");
    AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
    AST_DIV_RANGE: assert property (post_divide_ratio inside {[4'h2:4'h8]})
        else $error("divide ratio out of range");
    AST_PUMP_MAP: assert property (##1 pump_current_steps == ($past(charge_pump_gain) inside
        {[4'h1:4'h7]} ? {1'h0, $past(charge_pump_gain)} : $past(charge_pump_gain) == 4'h8
        ? 5'h10 : 5'h00)) else $error("pump current wrong");
    AST_RESYNC_CAUSE: assert property (chan_resync |-> $past(sync_event))
        else $error("resync without event");
    AST_RESTART_PULSE: assert property (cal_restart |=> !cal_restart)
        else $error("restart not a pulse");
    AST_RESTART_ON: assert property ($rose(synth_enable) |-> ##[0:1] cal_restart)
        else $error("enable without restart");
endmodule
bind synth2_control_regs synth2_regs_checker chk (.clk_sys(clk_sys), .arst_n(arst_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .synth_enable(synth_enable), .cal_restart(cal_restart),
    .post_divide_ratio(post_divide_ratio), .charge_pump_gain(charge_pump_gain),
    .pump_current_steps(pump_current_steps), .sync_event(sync_event),
    .chan_resync(chan_resync));

// [sim/tb_top.sv]
// self-checking bench for the synthesizer control registers
`timescale 1ns/1ps
module tb_top;
    logic clk_sys = 1'h0, arst_n = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, cal_done = 1'h0, sync_ev = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'h0, ratio, gain;
    logic awready, wready, bvalid, arready, rvalid, en, restart, dbl, resync;
    logic [1:0] bresp, rresp, resp;
    logic [4:0] steps;
    int err_count = 0, n_compared = 0, cyc = 0, n_restart = 0, n_resync = 0, n;
    // address, write data, read back, expected outputs
    logic [31:0] rows [20] = '{32'h44020202, 32'h44060602, 32'h440A0A03, 32'h440E0E04,
        32'h44121205, 32'h44161606, 32'h441A1A07, 32'h44FE1E08, 32'h48010101, 32'h48121282,
        32'h48030303, 32'h48141484, 32'h48050505, 32'h48161686, 32'h48070707, 32'h48080810,
        32'h48111181, 32'h48282810, 32'h48F83890, 32'h48181890};
    synth2_control_regs dut (.clk_sys(clk_sys), .arst_n(arst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cal_complete(cal_done), .synth_enable(en), .cal_restart(restart),
        .post_divide_ratio(ratio), .doubler_enable(dbl), .charge_pump_gain(gain),
        .pump_current_steps(steps), .sync_event(sync_ev), .chan_resync(resync));
    // clock
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    // pulse counters and timeout
    always @(posedge clk_sys) begin
        cyc++;
        if (restart === 1'h1) n_restart++;
        if (resync === 1'h1) n_resync++;
        if (cyc == 5000) begin
            err_count++;
            end_of_test;
        end
    end
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_compared++;
        if (got !== ex) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic end_of_test;
        if (err_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // write with address and data offered together
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        logic ah, wh;
        ah = 1'h0;
        wh = 1'h0;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(negedge clk_sys);
            ah = ah | awready;
            wh = wh | wready;
            @(posedge clk_sys);
            if (ah) awvalid <= 1'h0;
            if (wh) wvalid <= 1'h0;
        end while (!(ah && wh));
        do @(negedge clk_sys); while (bvalid !== 1'h1);
        r = bresp;
        @(posedge clk_sys);
        bready <= 1'h0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(negedge clk_sys); while (arready !== 1'h1);
        @(posedge clk_sys);
        arvalid <= 1'h0;
        do @(negedge clk_sys); while (rvalid !== 1'h1);
        d = rdata;
        r = rresp;
        @(posedge clk_sys);
        rready <= 1'h0;
    endtask
    task automatic settle;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic pulse;
        @(posedge clk_sys);
        sync_ev <= 1'h1;
        @(posedge clk_sys);
        sync_ev <= 1'h0;
        settle;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'h1;
        settle;
        axi_rd(8'h44, rd, resp);
        chk("ctrl0 reset", 32'h1E, rd);
        axi_rd(8'h48, rd, resp);
        chk("ctrl1 reset", 32'h18, rd);
        chk("reset outputs", 11'h630, {en, ratio, dbl, steps});
        axi_rd(8'h4C, rd, resp);
        chk("status busy", 32'h1082, rd);
        cal_done <= 1'h1;
        settle;
        axi_rd(8'h4C, rd, resp);
        chk("status done", 32'h1084, rd);
        // ordinary register rows
        foreach (rows[i]) begin
            axi_wr(rows[i][31:24], rows[i][23:16], 4'h1, resp);
            chk("bresp", 32'h0, resp);
            axi_rd(rows[i][31:24], rd, resp);
            chk("readback", rows[i][15:8], rd);
            settle;
            chk("outputs", rows[i][7:0], rows[i][26] ? {4'h0, ratio} : {dbl, 2'h0, steps});
            if (!rows[i][26]) chk("pump gain", rows[i][11:8], gain);
        end
        // powerdown stops the synthesizer
        axi_wr(8'h44, 8'h1F, 4'h1, resp);
        settle;
        axi_rd(8'h4C, rd, resp);
        chk("powerdown", 32'h1, {en, rd[2:0]});
        cal_done <= 1'h0;
        n = n_restart;
        axi_wr(8'h44, 8'h1E, 4'h1, resp);
        settle;
        axi_rd(8'h4C, rd, resp);
        chk("restart", {n + 1, 4'hA}, {n_restart, en, rd[2:0]});
        n = n_resync;
        pulse;
        chk("resync on", n + 1, n_resync);
        axi_wr(8'h44, 8'h1C, 4'h1, resp);
        pulse;
        chk("resync off", n + 1, n_resync);
        // unmapped, read-only and unstrobed writes
        axi_wr(8'h40, 8'hFF, 4'h1, resp);
        chk("unmapped write", 32'h2, resp);
        axi_rd(8'h40, rd, resp);
        chk("unmapped read", 32'h200, {resp, rd[7:0]});
        axi_wr(8'h4C, 8'hFF, 4'h1, resp);
        chk("status write", 32'h0, resp);
        axi_wr(8'h48, 8'h05, 4'h0, resp);
        axi_rd(8'h48, rd, resp);
        chk("no strobe", 32'h18, rd);
        // second reset in mid-run
        arst_n <= 1'h0;
        @(posedge clk_sys);
        arst_n <= 1'h1;
        settle;
        axi_rd(8'h44, rd, resp);
        chk("ctrl0 re-reset", 32'h1E, rd);
        end_of_test;
    end
endmodule
